/* rtl/rxs_link_mux.sv */
// Selects one receive link's control-cell values out of the per-link buses.
`timescale 1ns/1ns
module rxs_link_mux (
  // Link choice
  input  wire logic [3:0]   sel,
  // Per-link values, link n in slice n
  input  wire logic [127:0] link_cell_offset,
  input  wire logic [127:0] link_frame_seq,
  input  wire logic [127:0] link_change_seq,
  input  wire logic [127:0] link_oif_count,
  input  wire logic [15:0]  link_lif,
  input  wire logic [15:0]  link_lcd,
  input  wire logic [15:0]  link_is_ref,
  input  wire logic [79:0]  link_id,
  input  wire logic [31:0]  link_frame_len,
  input  wire logic [31:0]  link_ifsm_state,
  input  wire logic [31:0]  link_cd_state,
  // Values of the chosen link
  output logic      [7:0]   sel_cell_offset,
  output logic      [7:0]   sel_frame_seq,
  output logic      [7:0]   sel_change_seq,
  output logic      [7:0]   sel_oif_count,
  output logic              sel_lif,
  output logic              sel_lcd,
  output logic              sel_is_ref,
  output logic      [4:0]   sel_id,
  output logic      [1:0]   sel_frame_len,
  output logic      [1:0]   sel_ifsm_state,
  output logic      [1:0]   sel_cd_state
);

  // Plain indexed slices; the whole mux is combinational.
  always_comb begin
    sel_cell_offset = link_cell_offset[sel*rxs_pkg::BYTE_W +: rxs_pkg::BYTE_W];
    sel_frame_seq   = link_frame_seq[sel*rxs_pkg::BYTE_W +: rxs_pkg::BYTE_W];
    sel_change_seq  = link_change_seq[sel*rxs_pkg::BYTE_W +: rxs_pkg::BYTE_W];
    sel_oif_count   = link_oif_count[sel*rxs_pkg::BYTE_W +: rxs_pkg::BYTE_W];
    sel_lif         = link_lif[sel];
    sel_lcd         = link_lcd[sel];
    sel_is_ref      = link_is_ref[sel];
    sel_id          = link_id[sel*rxs_pkg::ID_W +: rxs_pkg::ID_W];
    sel_frame_len   = link_frame_len[sel*rxs_pkg::ST_W +: rxs_pkg::ST_W];
    sel_ifsm_state  = link_ifsm_state[sel*rxs_pkg::ST_W +: rxs_pkg::ST_W];
    sel_cd_state    = link_cd_state[sel*rxs_pkg::ST_W +: rxs_pkg::ST_W];
  end

endmodule

/* rtl/rxs_pkg.sv */
// Constants, types and decode helpers shared by the receive snapshot register bank.
package rxs_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_LINKS = 16;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned ID_W      = 5;
  localparam int unsigned ST_W      = 2;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_LINK_SELECT = 8'hDC;
  localparam logic [7:0] IDX_CELL_OFFSET = 8'hDF;
  localparam logic [7:0] IDX_FRAME_SEQ   = 8'hE0;
  localparam logic [7:0] IDX_CHANGE_SEQ  = 8'hE1;
  localparam logic [7:0] IDX_OIF_COUNT   = 8'hE2;
  localparam logic [7:0] IDX_LINK_IDENT  = 8'hE3;
  localparam logic [7:0] IDX_LINK_STATE  = 8'hE4;
  localparam logic [7:0] IDX_FRAME_SYNC  = 8'hE5;

  // ---------------------------------------------------------------------------
  // Reset values of the snapshot fields and the link select
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_CELL_OFFSET = 8'h00;
  localparam logic [7:0] RST_FRAME_SEQ   = 8'h01;
  localparam logic [7:0] RST_CHANGE_SEQ  = 8'h00;
  localparam logic [7:0] RST_OIF_COUNT   = 8'h00;
  localparam logic [7:0] RST_LINK_IDENT  = 8'h20;
  localparam logic [5:0] RST_LINK_STATE  = 6'h00;
  localparam logic [3:0] RST_LINK_SELECT = 4'h0;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned TOGGLE_BIT = 4;
  localparam int unsigned LIF_BIT    = 7;
  localparam int unsigned LCD_BIT    = 6;
  localparam int unsigned REF_BIT    = 5;
  localparam int unsigned FLEN_LSB   = 4;
  localparam int unsigned IFSM_LSB   = 2;
  localparam int unsigned CD_LSB     = 0;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RXS_ST_HUNT    = 2'b00,
    RXS_ST_PRESYNC = 2'b01,
    RXS_ST_SYNC    = 2'b10,
    RXS_ST_STUFF   = 2'b11
  } rxs_state_t;

  typedef enum logic [1:0] {
    RXS_M_32  = 2'b00,
    RXS_M_64  = 2'b01,
    RXS_M_128 = 2'b10,
    RXS_M_256 = 2'b11
  } rxs_flen_t;

  localparam logic [7:0] MASK_M_32  = 8'h1F;
  localparam logic [7:0] MASK_M_64  = 8'h3F;
  localparam logic [7:0] MASK_M_128 = 8'h7F;
  localparam logic [7:0] MASK_M_256 = 8'hFF;

  // Significant offset bits for a given frame length.
  function automatic logic [7:0] rxs_offset_mask(logic [1:0] flen);
    case (flen)
      RXS_M_32:  return MASK_M_32;
      RXS_M_64:  return MASK_M_64;
      RXS_M_128: return MASK_M_128;
      default:   return MASK_M_256;
    endcase
  endfunction

  // True while a frame state code means synchronised.
  function automatic logic rxs_is_sync(logic [1:0] st);
    return st == RXS_ST_SYNC;
  endfunction

endpackage

/* rtl/rxs_regs.sv */
// APB register bank reporting one selected receive link's control-cell snapshot.
`timescale 1ns/1ns

// What this block does
// - Snapshot registers refresh only when the link select register is written.
// - Offset register low byte holds the selected link's control-cell offset.
// - Offset keeps 8, 7, 6 or 5 bits for frame length 256, 128, 64, 32.
// - Frame sequence register low byte holds last sequence number, resetting to one.
// - Change sequence register low byte holds the last status-change number.
// - Out-of-frame counter register low byte holds the selected link's count.
// - Identity bit 7 is loss-of-frame state, bit 6 loss-of-delineation state.
// - Identity bit 5 is set for a reference link; register resets to 0x20.
// - Identity bits 4:0 hold the received link identifier.
// - State register bits 5:4 report the selected link's frame length.
// - State bits 3:2 give frame state: hunt, presync, sync, stuffed event.
// - State bits 1:0 give delineation state and never read as 11.
// - Unused upper bits of every register read as zero.
// - Sync status word has one live bit per link, high while synchronised.
// - Select register bit 4 inverts after every write to the block.
module rxs_regs (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Per-link values from the receive datapath, link n in slice n
  input  wire logic [127:0]  link_cell_offset,
  input  wire logic [127:0]  link_frame_seq,
  input  wire logic [127:0]  link_change_seq,
  input  wire logic [127:0]  link_oif_count,
  input  wire logic [15:0]   link_lif,
  input  wire logic [15:0]   link_lcd,
  input  wire logic [15:0]   link_is_ref,
  input  wire logic [79:0]   link_id,
  input  wire logic [31:0]   link_frame_len,
  input  wire logic [31:0]   link_ifsm_state,
  input  wire logic [31:0]   link_cd_state
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------

  logic [7:0]  reg_idx;
  logic        addr_aligned;
  logic        addr_ok;
  logic        setup_rd;
  logic        wr_done;
  logic        load_wr;
  logic [3:0]  wr_sel;

  // True when an index names one of our registers.
  function automatic logic rxs_mapped(logic [7:0] idx);
    case (idx)
      rxs_pkg::IDX_LINK_SELECT,
      rxs_pkg::IDX_CELL_OFFSET,
      rxs_pkg::IDX_FRAME_SEQ,
      rxs_pkg::IDX_CHANGE_SEQ,
      rxs_pkg::IDX_OIF_COUNT,
      rxs_pkg::IDX_LINK_IDENT,
      rxs_pkg::IDX_LINK_STATE,
      rxs_pkg::IDX_FRAME_SYNC: return 1'b1;
      default:                 return 1'b0;
    endcase
  endfunction

  // Word index from the byte address; any address off a word boundary is unmapped.
  assign reg_idx      = paddr[9:2];
  assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign addr_ok      = addr_aligned && rxs_mapped(reg_idx);

  // Read data is registered at the setup edge, so every access completes at once.
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_done  = psel & penable & pwrite;
  assign load_wr  = wr_done & addr_ok & (reg_idx == rxs_pkg::IDX_LINK_SELECT);
  assign wr_sel   = pwdata[3:0];

  // ---------------------------------------------------------------------------
  // Link select and write toggle
  // ---------------------------------------------------------------------------

  logic [3:0] sel_r;
  logic       toggle_r;

  // Link choice taken from the completed write.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= rxs_pkg::RST_LINK_SELECT;
    end else if (load_wr) begin
      sel_r <= wr_sel;
    end
  end

  // Flips on any completed write, mapped or not, so software can see it landed.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      toggle_r <= 1'b0;
    end else if (wr_done) begin
      toggle_r <= ~toggle_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Snapshot capture
  // ---------------------------------------------------------------------------

  logic [3:0] mux_sel;
  logic [7:0] m_offset;
  logic [7:0] m_fseq;
  logic [7:0] m_cseq;
  logic [7:0] m_oif;
  logic       m_lif;
  logic       m_lcd;
  logic       m_ref;
  logic [4:0] m_id;
  logic [1:0] m_flen;
  logic [1:0] m_ifsm;
  logic [1:0] m_cd;
  logic [7:0] offset_masked;
  logic [7:0] ident_nxt;
  logic [5:0] state_nxt;
  logic [1:0] cd_clean;

  // The mux looks at the incoming select during the load write so the
  // snapshot is already fresh for a read that follows back to back.
  assign mux_sel = load_wr ? wr_sel : sel_r;

  rxs_link_mux u_mux (
    .sel              (mux_sel),
    .link_cell_offset (link_cell_offset),
    .link_frame_seq   (link_frame_seq),
    .link_change_seq  (link_change_seq),
    .link_oif_count   (link_oif_count),
    .link_lif         (link_lif),
    .link_lcd         (link_lcd),
    .link_is_ref      (link_is_ref),
    .link_id          (link_id),
    .link_frame_len   (link_frame_len),
    .link_ifsm_state  (link_ifsm_state),
    .link_cd_state    (link_cd_state),
    .sel_cell_offset  (m_offset),
    .sel_frame_seq    (m_fseq),
    .sel_change_seq   (m_cseq),
    .sel_oif_count    (m_oif),
    .sel_lif          (m_lif),
    .sel_lcd          (m_lcd),
    .sel_is_ref       (m_ref),
    .sel_id           (m_id),
    .sel_frame_len    (m_flen),
    .sel_ifsm_state   (m_ifsm),
    .sel_cd_state     (m_cd)
  );

  // Shape the captured fields; a stray delineation code 11 reads as hunt.
  assign offset_masked = m_offset & rxs_pkg::rxs_offset_mask(m_flen);
  assign cd_clean      = (m_cd == rxs_pkg::RXS_ST_STUFF) ? rxs_pkg::RXS_ST_HUNT : m_cd;
  assign ident_nxt     = {m_lif, m_lcd, m_ref, m_id};
  assign state_nxt     = {m_flen, m_ifsm, cd_clean};

  logic [7:0] offset_r;
  logic [7:0] fseq_r;
  logic [7:0] cseq_r;
  logic [7:0] oif_r;
  logic [7:0] ident_r;
  logic [5:0] state_r;

  // All snapshot fields move together and only on the load write.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      offset_r <= rxs_pkg::RST_CELL_OFFSET;
      fseq_r   <= rxs_pkg::RST_FRAME_SEQ;
      cseq_r   <= rxs_pkg::RST_CHANGE_SEQ;
      oif_r    <= rxs_pkg::RST_OIF_COUNT;
      ident_r  <= rxs_pkg::RST_LINK_IDENT;
      state_r  <= rxs_pkg::RST_LINK_STATE;
    end else if (load_wr) begin
      offset_r <= offset_masked;
      fseq_r   <= m_fseq;
      cseq_r   <= m_cseq;
      oif_r    <= m_oif;
      ident_r  <= ident_nxt;
      state_r  <= state_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Live sync word and read path
  // ---------------------------------------------------------------------------

  logic [15:0] sync_word;
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;

  rxs_sync_status u_sync (
    .link_ifsm_state (link_ifsm_state),
    .sync_word       (sync_word)
  );

  // Narrow fields zero-extend; unmapped reads return zero with pslverr.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (addr_aligned) begin
      case (reg_idx)
        rxs_pkg::IDX_LINK_SELECT: rd_nxt = {27'h0, toggle_r, sel_r};
        rxs_pkg::IDX_CELL_OFFSET: rd_nxt = {24'h0, offset_r};
        rxs_pkg::IDX_FRAME_SEQ:   rd_nxt = {24'h0, fseq_r};
        rxs_pkg::IDX_CHANGE_SEQ:  rd_nxt = {24'h0, cseq_r};
        rxs_pkg::IDX_OIF_COUNT:   rd_nxt = {24'h0, oif_r};
        rxs_pkg::IDX_LINK_IDENT:  rd_nxt = {24'h0, ident_r};
        rxs_pkg::IDX_LINK_STATE:  rd_nxt = {26'h0, state_r};
        rxs_pkg::IDX_FRAME_SYNC:  rd_nxt = {16'h0, sync_word};
        default:                  rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data sampled at the setup edge; the sync word is as live as that edge.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata = prdata_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  property p_snap_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !load_wr |=> $stable(offset_r) && $stable(fseq_r) && $stable(cseq_r)
                   && $stable(oif_r) && $stable(ident_r) && $stable(state_r);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("Snapshot moved without load.");

  property p_offset_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> offset_r == $past(offset_masked);
  endproperty
  a_offset_load: assert property (p_offset_load) else $error("Offset not captured.");

  property p_offset_bits;
    @(posedge clk_sys) disable iff (!rst_b)
      (offset_r & ~rxs_pkg::rxs_offset_mask(state_r[rxs_pkg::FLEN_LSB +: rxs_pkg::ST_W])) == 8'h00;
  endproperty
  a_offset_bits: assert property (p_offset_bits) else $error("Offset exceeds frame length.");

  property p_fseq_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> fseq_r == $past(m_fseq);
  endproperty
  a_fseq_load: assert property (p_fseq_load) else $error("Frame sequence not captured.");

  property p_cseq_read;
    @(posedge clk_sys) disable iff (!rst_b)
      setup_rd && addr_aligned && reg_idx == rxs_pkg::IDX_CHANGE_SEQ
      |=> prdata == {24'h0, $past(cseq_r)};
  endproperty
  a_cseq_read: assert property (p_cseq_read) else $error("Change sequence read wrong.");

  property p_oif_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> oif_r == $past(m_oif) ##1 (load_wr || oif_r == $past(oif_r));
  endproperty
  a_oif_load: assert property (p_oif_load) else $error("Out-of-frame count wrong.");

  property p_ident_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> ident_r[rxs_pkg::LIF_BIT] == $past(m_lif)
                  && ident_r[rxs_pkg::LCD_BIT] == $past(m_lcd);
  endproperty
  a_ident_load: assert property (p_ident_load) else $error("Loss states misplaced.");

  property p_ref_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> ident_r[rxs_pkg::REF_BIT] == $past(m_ref)
                  && ident_r[rxs_pkg::ID_W-1:0] == $past(m_id);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("Reference or identifier wrong.");

  property p_state_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> state_r[rxs_pkg::FLEN_LSB +: rxs_pkg::ST_W] == $past(m_flen)
                  && state_r[rxs_pkg::IFSM_LSB +: rxs_pkg::ST_W] == $past(m_ifsm);
  endproperty
  a_state_load: assert property (p_state_load) else $error("Frame fields wrong.");

  property p_cd_never_3;
    @(posedge clk_sys) disable iff (!rst_b)
      state_r[rxs_pkg::CD_LSB +: rxs_pkg::ST_W] != rxs_pkg::RXS_ST_STUFF;
  endproperty
  a_cd_never_3: assert property (p_cd_never_3) else $error("Delineation state reads 11.");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (!rst_b)
      setup_rd && reg_idx != rxs_pkg::IDX_FRAME_SYNC |=> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Unused bits not zero.");

  property p_sync_read;
    @(posedge clk_sys) disable iff (!rst_b)
      setup_rd && addr_aligned && reg_idx == rxs_pkg::IDX_FRAME_SYNC
      |=> prdata[15:0] == $past(sync_word) && prdata[31:16] == 16'h0000;
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("Sync word read wrong.");

  property p_sync_live;
    @(posedge clk_sys) disable iff (!rst_b)
      sync_word[0] == (link_ifsm_state[1:0] == rxs_pkg::RXS_ST_SYNC)
      && sync_word[15] == (link_ifsm_state[31:30] == rxs_pkg::RXS_ST_SYNC);
  endproperty
  a_sync_live: assert property (p_sync_live) else $error("Sync bit not live.");

  property p_sel_load;
    @(posedge clk_sys) disable iff (!rst_b)
      load_wr |=> sel_r == $past(wr_sel);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("Link select not stored.");

  // The toggle must read back at its own bit, beside the stored select.
  property p_sel_read;
    @(posedge clk_sys) disable iff (!rst_b)
      setup_rd && addr_aligned && reg_idx == rxs_pkg::IDX_LINK_SELECT
      |=> prdata[rxs_pkg::TOGGLE_BIT] == $past(toggle_r)
          && prdata[rxs_pkg::SEL_W-1:0] == $past(sel_r);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("Link select read wrong.");

  property p_toggle;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_done |=> toggle_r != $past(toggle_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Write toggle did not flip.");

  property p_toggle_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !wr_done |=> $stable(toggle_r);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("Toggle moved without write.");

endmodule

/* rtl/rxs_sync_status.sv */
// Builds the live one-bit-per-link frame synchronisation word.
`timescale 1ns/1ns
module rxs_sync_status (
  // Frame state of every link, link n in slice n
  input  wire logic [31:0] link_ifsm_state,
  // One bit per link, high while synchronised
  output logic      [15:0] sync_word
);

  // One decoder per link; nothing is latched so the word follows the links.
  for (genvar i = 0; i < rxs_pkg::NUM_LINKS; i++) begin : g_link
    assign sync_word[i] = rxs_pkg::rxs_is_sync(link_ifsm_state[i*rxs_pkg::ST_W +: rxs_pkg::ST_W]);
  end

endmodule

/* testbench/rxs_regs_bench.sv */
// Self-checking testbench for the receive snapshot register bank.
`timescale 1ns/1ns
module rxs_regs_bench;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic         clk_sys = 1'b0;
  logic         rst_b   = 1'b0;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [11:0]  paddr   = 12'h000;
  logic [31:0]  pwdata  = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [127:0] c_off = '0, f_seq = '0, c_seq = '0, oif = '0;
  logic [15:0]  lif = '0, lcd = '0, is_ref = '0;
  logic [79:0]  lid = '0;
  logic [31:0]  flen = '0, ifsm = '0, cds = '0;
  int           error_cnt = 0;
  int           checked   = 0;
  logic         tog       = 1'b0;
  logic [31:0]  rd;
  logic         er;
  // Ored into the byte address to reach off-boundary or out-of-range addresses.
  logic [11:0]  a_off     = 12'h000;
  // Rows: link, expected masked offset, expected state field.
  typedef struct packed { logic [3:0] ln; logic [7:0] off; logic [5:0] st; } rxs_row_t;
  rxs_row_t rows [7] = '{'{4'h0, 8'h10, 6'h00}, '{4'h3, 8'hF3, 6'h31}, '{4'h6, 8'h76, 6'h24},
                         '{4'h9, 8'h39, 6'h18}, '{4'hE, 8'h7E, 6'h2C}, '{4'hF, 8'hFF, 6'h3C},
                         '{4'h5, 8'h35, 6'h16}};
  logic [7:0]  rst_idx [8] = '{8'hDC, 8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5};
  logic [31:0] rst_val [8] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h20, 32'h0, 32'h0F00};

  rxs_regs u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_cell_offset(c_off), .link_frame_seq(f_seq), .link_change_seq(c_seq),
    .link_oif_count(oif), .link_lif(lif), .link_lcd(lcd), .link_is_ref(is_ref),
    .link_id(lid), .link_frame_len(flen), .link_ifsm_state(ifsm), .link_cd_state(cds));

  // Half period of 50 ns gives the 10 MHz system clock.
  always #50 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00} | a_off;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (wr) tog = ~tog;
  endtask

  // Reads a register and expects a clean response with the given word.
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0);
  endtask

  // Drives every link's values; sync0 puts link 0 into frame sync.
  task automatic drive_links(input logic [7:0] bump, input logic sync0);
    logic [3:0] k;
    @(posedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      c_off[8*i +: 8]  <= 8'hF0 + 8'(i);
      f_seq[8*i +: 8]  <= 8'h10 + 8'(i) + bump;
      c_seq[8*i +: 8]  <= 8'h40 + 8'(i);
      oif[8*i +: 8]    <= 8'h80 + 8'(i);
      lif[i]           <= k[0];
      lcd[i]           <= k[1];
      is_ref[i]        <= k[2];
      lid[5*i +: 5]    <= 5'h1F - {1'b0, k};
      flen[2*i +: 2]   <= k[1:0];
      ifsm[2*i +: 2]   <= (i == 0 && sync0) ? 2'b10 : k[3:2];
      cds[2*i +: 2]    <= k[2:1];
    end
  endtask

  // Holds reset for five edges, then checks every reset value.
  task automatic reset_and_check();
    rst_b <= 1'b0;
    drive_links(8'h00, 1'b0);
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    tog = 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(rst_idx[i], rst_val[i]);
    $display("reset test done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  // Reset check first, then the table rows, live status, hold, refusal and closing reset cases.
  initial begin
    logic [3:0] n;
    reset_and_check();
    foreach (rows[r]) begin
      n = rows[r].ln;
      apb(1'b1, 8'hDC, {28'h0, n}, rd, er);
      rd_chk(8'hDC, {27'h0, tog, n});
      rd_chk(8'hDF, {24'h0, rows[r].off});
      rd_chk(8'hE0, {24'h0, 8'h10 + {4'h0, n}});
      rd_chk(8'hE1, {24'h0, 8'h40 + {4'h0, n}});
      rd_chk(8'hE2, {24'h0, 8'h80 + {4'h0, n}});
      rd_chk(8'hE3, {24'h0, n[0], n[1], n[2], 5'h1F - {1'b0, n}});
      rd_chk(8'hE4, {26'h0, rows[r].st});
    end
    $display("row test done");
    // The sync word follows the live state with no select write.
    drive_links(8'h00, 1'b1);
    rd_chk(8'hE5, 32'h0F01);
    drive_links(8'h00, 1'b0);
    rd_chk(8'hE5, 32'h0F00);
    $display("sync word test done");
    // Snapshot holds while the link changes, and refreshes on the next select write.
    apb(1'b1, 8'hDC, 32'h3, rd, er);
    drive_links(8'h20, 1'b0);
    rd_chk(8'hE0, 32'h13);
    apb(1'b1, 8'hDC, 32'h3, rd, er);
    rd_chk(8'hE0, 32'h33);
    $display("hold test done");
    // Refused writes still flip the toggle and change no snapshot value.
    apb(1'b1, 8'hE6, 32'hF, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'hDF, 32'hFFFF, rd, er);
    // Off-boundary and out-of-range addresses are unmapped: no load, error flagged.
    a_off = 12'h001;
    apb(1'b1, 8'hDC, 32'h5, rd, er);
    chk({31'h0, er}, 32'h1);
    a_off = 12'h400;
    apb(1'b0, 8'hDF, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    a_off = 12'h000;
    rd_chk(8'hDC, {27'h0, tog, 4'h3});
    rd_chk(8'hDF, 32'hF3);
    apb(1'b0, 8'hE7, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("refusal test done");
    reset_and_check();
    close_out();
  end

  // A hang is cut short well after the expected few hundred cycles.
  initial begin
    #(100 * 5000);
    error_cnt++;
    close_out();
  end
endmodule
